// [bench/pemon_host_model.sv]
// Host controller model that issues position references to the monitor
`timescale 1ns/1ns
`default_nettype none
module pemon_host_model (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic signed [15:0] step_i,
    output logic ref_valid_o,
    output logic signed [15:0] ref_step_o
);
    // ==========================================================
    // Reference stream
    // Quiet start so the monitor sees no reference before the first request
    initial begin
        ref_valid_o = 1'b0;
        ref_step_o = 16'h0000;
    end
    // One reference per cycle while asked; step lines toggle when idle,
    // so a stale value can never pass for a real reference
    always @(posedge clk_i) begin
        ref_valid_o <= go_i;
        ref_step_o <= go_i ? step_i : ~ref_step_o;
    end
endmodule // pemon_host_model
`default_nettype wire

// [bench/pemon_top_tb.sv]
// Self-checking testbench of the position error overflow monitor
`timescale 1ns/1ns
`default_nettype none
module pemon_top_tb
    import pemon_pkg::*;
;
    // ==========================================================
    // Bench signals
    logic mclk = 1'b0; // 50 MHz clock
    logic rst = 1'b1; // Synchronous reset
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic hready; // Single slave: its hreadyout is the bus hready
    logic hresp;
    logic go = 1'b0; // Ask the host model for references
    logic signed [15:0] step = 16'sh0000;
    logic ref_valid;
    logic signed [15:0] ref_step;
    logic signed [15:0] fb = 16'sh0000; // Feedback pulses
    logic servo = 1'b0; // Motor power
    logic ovf, pon, capovf, stop, clr, lim_en, irq;
    logic [13:0] lim;
    logic [31:0] r; // Last bus read
    int mismatches = 0;
    int num_checks = 0;
    // ==========================================================
    // Clock, design and partner
    initial begin
        forever #10 mclk = ~mclk;
    end
    pemon_top pemon_top_i (.MCLK_I(mclk), .SYS_RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
        .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
        .REF_VALID_I(ref_valid), .REF_STEP_I(ref_step), .FB_STEP_I(fb), .SERVO_ON_I(servo),
        .ERROR_OVERFLOW_ALARM_O(ovf), .POWERON_OVERFLOW_ALARM_O(pon),
        .CAPPED_SPEED_OVERFLOW_ALARM_O(capovf), .MOTOR_STOP_O(stop), .CLEARING_O(clr),
        .SPEED_LIMIT_EN_O(lim_en), .SPEED_LIMIT_O(lim), .IRQ_O(irq));
    pemon_host_model pemon_host_model_i (.clk_i(mclk), .go_i(go), .step_i(step),
        .ref_valid_o(ref_valid), .ref_step_o(ref_step));
    // ==========================================================
    // Tasks
    // Compare and count; unknowns never match
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] e);
        num_checks++;
        if (seen !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, seen);
        end
    endtask
    // Wait for hready; a hung slave is left to the watchdog
    task automatic wait_rdy;
        do begin
            @(posedge mclk);
        end while (hready !== 1'b1);
    endtask
    // One AHB-Lite single word transfer; signals change only on a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h00_0000, a};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
        bus(1'b0, a, 32'h0000_0000);
        chk(n, r, e);
        chk("hresp", 32'(hresp), 32'h0000_0000);
    endtask
    // Let registered outputs settle, then sample off the edge
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Burst of n references of one step size from the host model
    task automatic send(input int n, input logic signed [15:0] s);
        @(posedge mclk);
        go <= 1'b1;
        step <= s;
        repeat (n) @(posedge mclk);
        go <= 1'b0;
        wt(3);
    endtask
    // One cycle of feedback pulses
    task automatic drain(input logic signed [15:0] v);
        @(posedge mclk);
        fb <= v;
        @(posedge mclk);
        fb <= 16'sh0000;
        wt(3);
    endtask
    // Expected steady error from speed, resolution, gain and gear 1:1
    function automatic logic [31:0] expect_err(input logic [15:0] gain);
        return 32'(64'(PEM_MOTSPD_RST) * 64'(PEM_ENC_RES) * 64'(PEM_GAIN_SCALE)
            / (64'(PEM_SEC_PER_MIN) * 64'(gain)));
    endfunction
    task automatic stop_test;
        $display("num_checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Watchdog: the whole run needs well under 2000 cycles
    initial begin
        repeat (2000) @(posedge mclk);
        mismatches++;
        stop_test();
    end
    // ==========================================================
    // Tests
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        // Defaults and read-only places
        rchk(PEM_LEVEL_ADDR, 32'(PEM_LEVEL_RST), "level");
        rchk(PEM_PONTHR_ADDR, 32'(PEM_LEVEL_RST), "ponthr");
        rchk(PEM_CAP_ADDR, 32'(PEM_CAP_RST), "cap");
        rchk(PEM_EXPECT_ADDR, expect_err(PEM_GAIN_RST), "expect");
        chk("margin", 2 * r, 32'(PEM_LEVEL_RST));
        rchk(PEM_SHOWN_ADDR, 32'h0000_0000, "shown off");
        rchk(8'h3C, 32'h0000_0000, "unmapped");
        // Display select and follower gain selection
        wr(PEM_FGAIN_ADDR, 32'h0000_0320);
        wr(PEM_CTRL_ADDR, 32'h0000_0006);
        wt(2);
        rchk(PEM_SHOWN_ADDR, 32'(PEM_GAIN_RST), "shown on");
        rchk(PEM_EXPECT_ADDR, expect_err(16'h0320), "expect follower");
        wr(PEM_CTRL_ADDR, 32'h0000_0000);
        // Quarter speed with gear 2:1 halves the default; zero denominator clamps to one
        wr(PEM_GNUM_ADDR, 32'h0000_0002);
        wr(PEM_GDEN_ADDR, 32'h0000_0000);
        wr(PEM_MOTSPD_ADDR, 32'h0000_05DC);
        wt(2);
        rchk(PEM_GDEN_ADDR, 32'h0000_0001, "gden min");
        rchk(PEM_EXPECT_ADDR, expect_err(PEM_GAIN_RST) / 2, "expect gear");
        // Range clamps take effect at once
        wr(PEM_LEVEL_ADDR, 32'h0000_0000);
        rchk(PEM_LEVEL_ADDR, 32'h0000_0001, "level min");
        wr(PEM_CAP_ADDR, 32'h0000_4E20);
        rchk(PEM_CAP_ADDR, 32'h0000_2710, "cap max");
        wr(PEM_CAP_ADDR, 32'h0000_0064);
        wt(1);
        chk("limit out", 32'(lim), 32'h0000_0064);
        // Accumulation; no error overflow alarm outside position mode
        send(10, 16'sh0064);
        rchk(PEM_ERR_ADDR, 32'h0000_03E8, "err");
        wr(PEM_LEVEL_ADDR, 32'h0000_01F4);
        wr(PEM_IEN_ADDR, 32'h0000_0001);
        wt(3);
        chk("ovf mode off", 32'(ovf), 32'h0);
        wr(PEM_CTRL_ADDR, 32'h0000_0001);
        wt(3);
        chk("ovf", 32'(ovf), 32'h1);
        chk("stop", 32'(stop), 32'h1);
        chk("irq", 32'(irq), 32'h1);
        // Clear while the error persists: bit sets again
        wr(PEM_ICLR_ADDR, 32'h0000_0001);
        wt(2);
        rchk(PEM_STAT_ADDR, 32'h0000_0001, "status resets");
        drain(16'sh03E8);
        wr(PEM_ICLR_ADDR, 32'h0000_0007);
        wt(2);
        chk("irq cleared", 32'(irq), 32'h0);
        // Negative error alarms too; masked interrupt stays low
        send(10, -16'sh0064);
        chk("ovf negative", 32'(ovf), 32'h1);
        wr(PEM_IEN_ADDR, 32'h0000_0000);
        wt(2);
        chk("irq masked", 32'(irq), 32'h0);
        drain(-16'sh03E8);
        wr(PEM_ICLR_ADDR, 32'h0000_0007);
        wr(PEM_CTRL_ADDR, 32'h0000_0000);
        // Power-on with residual error above threshold
        wr(PEM_PONTHR_ADDR, 32'h0000_01F4);
        send(10, 16'sh0064);
        @(posedge mclk);
        servo <= 1'b1;
        wt(3);
        chk("pon", 32'(pon), 32'h1);
        chk("cap active", 32'(lim_en), 32'h1);
        chk("clearing", 32'(clr), 32'h1);
        // References under the speed cap while the error is already past the level
        send(2, 16'sh0064);
        chk("capovf", 32'(capovf), 32'h1);
        chk("ovf off mode", 32'(ovf), 32'h0);
        drain(16'sh04B0);
        chk("cap released", 32'(lim_en), 32'h0);
        chk("cleared", 32'(clr), 32'h0);
        rchk(PEM_STAT_ADDR, 32'h0000_0006, "status");
        stop_test();
    end
endmodule // pemon_top_tb
`default_nettype wire

// [verilog/pemon_cmp.sv]
// Magnitude-over-limit comparator for the signed position error
`timescale 1ns/1ns
`default_nettype none
module pemon_cmp
    import pemon_pkg::*;
#(
    parameter int W = 32
) (
    input wire logic signed [W-1:0] value_i,
    input wire logic [29:0] limit_i,
    output logic over_o
);
    // ==========================================================
    // Magnitude, widened so the most negative value is safe
    logic [W:0] mag;
    // Both signs are folded to one magnitude
    always_comb begin
        if (value_i[W-1]) begin
            mag = (W+1)'(0) - {value_i[W-1], value_i};
        end else begin
            mag = {1'b0, value_i};
        end
        over_o = mag > (W+1)'(limit_i);
    end
endmodule // pemon_cmp
`default_nettype wire

// [verilog/pemon_pkg.sv]
// Package of register map, field layout and reset values of the position error monitor
package pemon_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] PEM_CTRL_ADDR = 8'h00; // Mode and select bits
    localparam logic [7:0] PEM_LEVEL_ADDR = 8'h04; // error_alarm_level
    localparam logic [7:0] PEM_PONTHR_ADDR = 8'h08; // poweron_error_threshold
    localparam logic [7:0] PEM_CAP_ADDR = 8'h0C; // poweron_speed_cap
    localparam logic [7:0] PEM_LGAIN_ADDR = 8'h10; // loop_gain
    localparam logic [7:0] PEM_FGAIN_ADDR = 8'h14; // follower_gain
    localparam logic [7:0] PEM_GNUM_ADDR = 8'h18; // gear_numerator
    localparam logic [7:0] PEM_GDEN_ADDR = 8'h1C; // gear_denominator
    localparam logic [7:0] PEM_ERR_ADDR = 8'h20; // Live position error
    localparam logic [7:0] PEM_STAT_ADDR = 8'h24; // Sticky alarm status
    localparam logic [7:0] PEM_IEN_ADDR = 8'h28; // Interrupt enable
    localparam logic [7:0] PEM_ICLR_ADDR = 8'h2C; // Write-one-to-clear
    localparam logic [7:0] PEM_SHOWN_ADDR = 8'h30; // Displayed loop gain
    localparam logic [7:0] PEM_EXPECT_ADDR = 8'h34; // Expected steady error
    localparam logic [7:0] PEM_MOTSPD_ADDR = 8'h38; // Speed used for expectation
    // ==========================================================
    // Control bit positions
    localparam int PEM_CTRL_MODE = 0; // Position control mode
    localparam int PEM_CTRL_FSEL = 1; // follower_select
    localparam int PEM_CTRL_DISP = 2; // param_display_select
    localparam logic PEM_FSEL_ON = 1'b1; // Model following enabled code
    localparam logic PEM_DISP_ALL = 1'b1; // Show all parameters
    // Status bit positions
    localparam int PEM_ST_OVF = 0; // error_overflow_alarm
    localparam int PEM_ST_PON = 1; // poweron_overflow_alarm
    localparam int PEM_ST_CAP = 2; // capped_speed_overflow_alarm
    localparam int PEM_NST = 3;
    // ==========================================================
    // Ranges and reset values
    localparam logic [29:0] PEM_LEVEL_MIN = 30'h0000_0001;
    localparam logic [29:0] PEM_LEVEL_MAX = 30'h3FFF_FFFF; // 1073741823
    localparam logic [29:0] PEM_LEVEL_RST = 30'h0050_0000; // 5242880
    localparam logic [13:0] PEM_CAP_MAX = 14'h2710; // 10000 rpm
    localparam logic [13:0] PEM_CAP_RST = 14'h2710; // 10000 rpm
    localparam logic [15:0] PEM_GAIN_MIN = 16'h0001;
    localparam logic [15:0] PEM_GAIN_RST = 16'h0190; // 40.0 /s
    localparam logic [15:0] PEM_GEAR_RST = 16'h0001;
    localparam logic [13:0] PEM_MOTSPD_RST = 14'h1770; // 6000 rpm
    // Expected error arithmetic
    localparam logic [31:0] PEM_ENC_RES = 32'h0010_0000; // Pulses per rev
    localparam logic [5:0] PEM_SEC_PER_MIN = 6'h3C; // 60
    localparam logic [3:0] PEM_GAIN_SCALE = 4'hA; // Gain unit is 0.1/s
endpackage : pemon_pkg

// [verilog/pemon_top.sv]
// Position error overflow monitor with AHB-Lite register slave
//
// Notes on behaviour
// - error counter accumulates reference minus feedback
// - overflow supervision only in position control mode (the power-on and capped speed overflow alarms are checked in any mode)
// - error above level raises alarm, stops motor
// - alarm level 1..1073741823, default 5242880, immediate
// - expected error from speed, resolution, gain, gear
// - follower gain replaces loop gain when selected
// - loop gain display hidden unless display-all set; loop_gain register always readable
// - residual error at power-on is driven out
// - power-on threshold 1..1073741823, default 5242880
// - power-on with error above threshold alarms
// - speed capped while residual error clears
// - speed cap 0..10000 rpm, default 10000, immediate
// - capped speed plus references over level alarms
`timescale 1ns/1ns
`default_nettype none
module pemon_top
    import pemon_pkg::*;
(
    input wire logic MCLK_I,
    input wire logic SYS_RST_I,
    // AHB-Lite slave
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    // Position path
    input wire logic REF_VALID_I,
    input wire logic signed [15:0] REF_STEP_I,
    input wire logic signed [15:0] FB_STEP_I,
    input wire logic SERVO_ON_I,
    // Protective outputs
    output logic ERROR_OVERFLOW_ALARM_O,
    output logic POWERON_OVERFLOW_ALARM_O,
    output logic CAPPED_SPEED_OVERFLOW_ALARM_O,
    output logic MOTOR_STOP_O,
    output logic CLEARING_O,
    output logic SPEED_LIMIT_EN_O,
    output logic [13:0] SPEED_LIMIT_O,
    output logic IRQ_O
);
    // ==========================================================
    // State
    typedef struct packed {
        logic [2:0] ctrl; // Mode, follower select, display select
        logic [29:0] level; // error_alarm_level
        logic [29:0] pon_thr; // poweron_error_threshold
        logic [13:0] cap; // poweron_speed_cap
        logic [15:0] lgain; // loop_gain
        logic [15:0] fgain; // follower_gain
        logic [15:0] gnum; // gear_numerator
        logic [15:0] gden; // gear_denominator
        logic [13:0] motspd; // Speed for expected error
        logic signed [31:0] err; // Position error counter
        logic servo; // Last sampled servo-on
        logic cap_act; // Power-on speed cap in force
        logic [PEM_NST-1:0] stat; // Sticky alarms
        logic [PEM_NST-1:0] ien; // Interrupt enables
        logic [31:0] expect_err; // Expected steady error
        logic d_wr; // Pending write data phase
        logic [7:0] d_addr; // Address of that write
        logic [31:0] rdata; // Read data for data phase
    } pemon_state_s;
    pemon_state_s s; // Current state
    pemon_state_s next_s; // Next state
    // ==========================================================
    // Combinational helpers
    logic over_lvl; // Error magnitude above alarm level
    logic over_pon; // Error magnitude above power-on threshold
    logic addr_take; // Address phase accepted
    logic servo_rise; // Motor power switched on
    logic [15:0] gain_sel; // Gain used in expectation
    logic [31:0] shown_gain; // Loop gain as displayed
    logic [31:0] reg_val; // Register selected for reading
    logic [79:0] exp_num; // Expectation numerator
    logic [79:0] exp_den; // Expectation denominator
    logic [79:0] exp_quo; // Expectation quotient
    logic signed [31:0] delta; // Net step this cycle

    // Main level check
    pemon_cmp #(
        .W(32)
    ) u_cmp_lvl (
        .value_i(s.err),
        .limit_i(s.level),
        .over_o(over_lvl)
    );
    // Power-on threshold check
    pemon_cmp #(
        .W(32)
    ) u_cmp_pon (
        .value_i(s.err),
        .limit_i(s.pon_thr),
        .over_o(over_pon)
    );

    // ==========================================================
    // Bus decode and read mux
    always_comb begin
        addr_take = HSEL_I && HTRANS_I[1] && HREADY_I;
        servo_rise = SERVO_ON_I && !s.servo;
        delta = REF_VALID_I ? 32'(REF_STEP_I) : 32'h0000_0000;
        delta = delta - 32'(FB_STEP_I);
        // Model following swaps in its own gain
        if (s.ctrl[PEM_CTRL_FSEL] == PEM_FSEL_ON) begin
            gain_sel = s.fgain;
        end else begin
            gain_sel = s.lgain;
        end
        // Hidden unless all parameters are on display
        if (s.ctrl[PEM_CTRL_DISP] == PEM_DISP_ALL) begin
            shown_gain = {16'h0000, s.lgain};
        end else begin
            shown_gain = 32'h0000_0000;
        end
        // Gain is in 0.1/s, so the ten moves to the numerator
        exp_num = 80'(s.motspd) * 80'(PEM_ENC_RES) * 80'(PEM_GAIN_SCALE)
            * 80'(s.gnum);
        exp_den = 80'(PEM_SEC_PER_MIN) * 80'(gain_sel) * 80'(s.gden);
        exp_quo = exp_num / exp_den; // Divisor never zero, minimums held
        unique case (HADDR_I[7:0])
            PEM_CTRL_ADDR: reg_val = {29'h0000_0000, s.ctrl};
            PEM_LEVEL_ADDR: reg_val = {2'h0, s.level};
            PEM_PONTHR_ADDR: reg_val = {2'h0, s.pon_thr};
            PEM_CAP_ADDR: reg_val = {18'h0_0000, s.cap};
            PEM_LGAIN_ADDR: reg_val = {16'h0000, s.lgain};
            PEM_FGAIN_ADDR: reg_val = {16'h0000, s.fgain};
            PEM_GNUM_ADDR: reg_val = {16'h0000, s.gnum};
            PEM_GDEN_ADDR: reg_val = {16'h0000, s.gden};
            PEM_ERR_ADDR: reg_val = s.err;
            PEM_STAT_ADDR: reg_val = {29'h0000_0000, s.stat};
            PEM_IEN_ADDR: reg_val = {29'h0000_0000, s.ien};
            PEM_SHOWN_ADDR: reg_val = shown_gain;
            PEM_EXPECT_ADDR: reg_val = s.expect_err;
            PEM_MOTSPD_ADDR: reg_val = {18'h0_0000, s.motspd};
            default: reg_val = 32'h0000_0000; // Unmapped reads zero
        endcase
        if (HADDR_I[31:8] != 24'h00_0000) begin
            reg_val = 32'h0000_0000; // Outside the block's window
        end
    end

    // ==========================================================
    // Next-state logic
    always_comb begin
        next_s = s;
        next_s.servo = SERVO_ON_I;
        next_s.err = s.err + delta;
        // Saturate the expectation at the word width
        if (exp_quo[79:32] != 48'h0000_0000_0000) begin
            next_s.expect_err = 32'hFFFF_FFFF;
        end else begin
            next_s.expect_err = exp_quo[31:0];
        end
        // Bus address phase: capture write, prepare read data
        next_s.d_wr = addr_take && HWRITE_I && (HADDR_I[31:8] == 24'h00_0000);
        next_s.d_addr = HADDR_I[7:0];
        if (addr_take && !HWRITE_I) begin
            next_s.rdata = reg_val;
        end
        // Write data phase; new settings act from the next cycle
        if (s.d_wr) begin
            unique case (s.d_addr)
                PEM_CTRL_ADDR: next_s.ctrl = HWDATA_I[2:0];
                PEM_LEVEL_ADDR: begin
                    if (HWDATA_I[31:30] != 2'h0) begin
                        next_s.level = PEM_LEVEL_MAX;
                    end else if (HWDATA_I[29:0] < PEM_LEVEL_MIN) begin
                        next_s.level = PEM_LEVEL_MIN;
                    end else begin
                        next_s.level = HWDATA_I[29:0];
                    end
                end
                PEM_PONTHR_ADDR: begin
                    if (HWDATA_I[31:30] != 2'h0) begin
                        next_s.pon_thr = PEM_LEVEL_MAX;
                    end else if (HWDATA_I[29:0] < PEM_LEVEL_MIN) begin
                        next_s.pon_thr = PEM_LEVEL_MIN;
                    end else begin
                        next_s.pon_thr = HWDATA_I[29:0];
                    end
                end
                PEM_CAP_ADDR: begin
                    if (HWDATA_I > 32'(PEM_CAP_MAX)) begin
                        next_s.cap = PEM_CAP_MAX;
                    end else begin
                        next_s.cap = HWDATA_I[13:0];
                    end
                end
                // Zero gains or denominators would break the divide
                PEM_LGAIN_ADDR: next_s.lgain = (HWDATA_I[15:0] < PEM_GAIN_MIN)
                    ? PEM_GAIN_MIN : HWDATA_I[15:0];
                PEM_FGAIN_ADDR: next_s.fgain = (HWDATA_I[15:0] < PEM_GAIN_MIN)
                    ? PEM_GAIN_MIN : HWDATA_I[15:0];
                PEM_GNUM_ADDR: next_s.gnum = (HWDATA_I[15:0] < PEM_GAIN_MIN)
                    ? PEM_GAIN_MIN : HWDATA_I[15:0];
                PEM_GDEN_ADDR: next_s.gden = (HWDATA_I[15:0] < PEM_GAIN_MIN)
                    ? PEM_GAIN_MIN : HWDATA_I[15:0];
                PEM_MOTSPD_ADDR: next_s.motspd = HWDATA_I[13:0];
                PEM_IEN_ADDR: next_s.ien = HWDATA_I[PEM_NST-1:0];
                PEM_ICLR_ADDR: next_s.stat = s.stat & ~HWDATA_I[PEM_NST-1:0];
                default: ; // Read-only or unmapped: ignored
            endcase
        end
        // Speed cap: armed by power-on with residual error
        if (!SERVO_ON_I) begin
            next_s.cap_act = 1'b0;
        end else if (servo_rise && (s.err != 32'sh0000_0000)) begin
            next_s.cap_act = 1'b1;
        end else if (s.err == 32'sh0000_0000) begin
            next_s.cap_act = 1'b0; // Counter drained
        end
        // Alarm sets come last so they win over a clear
        if (s.ctrl[PEM_CTRL_MODE] && over_lvl) begin
            next_s.stat[PEM_ST_OVF] = 1'b1;
        end
        if (servo_rise && over_pon) begin
            next_s.stat[PEM_ST_PON] = 1'b1;
        end
        if (s.cap_act && REF_VALID_I && over_lvl) begin
            next_s.stat[PEM_ST_CAP] = 1'b1;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            s <= '0;
            s.level <= PEM_LEVEL_RST;
            s.pon_thr <= PEM_LEVEL_RST;
            s.cap <= PEM_CAP_RST;
            s.lgain <= PEM_GAIN_RST;
            s.fgain <= PEM_GAIN_RST;
            s.gnum <= PEM_GEAR_RST;
            s.gden <= PEM_GEAR_RST;
            s.motspd <= PEM_MOTSPD_RST;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Outputs
    always_comb begin
        HRDATA_O = s.rdata;
        HREADYOUT_O = 1'b1; // Zero wait states
        HRESP_O = 1'b0; // Always OKAY
        ERROR_OVERFLOW_ALARM_O = s.stat[PEM_ST_OVF];
        POWERON_OVERFLOW_ALARM_O = s.stat[PEM_ST_PON];
        CAPPED_SPEED_OVERFLOW_ALARM_O = s.stat[PEM_ST_CAP];
        MOTOR_STOP_O = |s.stat;
        CLEARING_O = s.cap_act;
        SPEED_LIMIT_EN_O = s.cap_act;
        SPEED_LIMIT_O = s.cap;
        IRQ_O = |(s.stat & s.ien);
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (SYS_RST_I);

    property p_err_acc;
        ##1 1'b1 |-> s.err == $past(s.err) + $past(delta);
    endproperty
    a_err_acc: assert property (p_err_acc)
        else $error("error counter did not accumulate");

    property p_mode_only;
        $rose(ERROR_OVERFLOW_ALARM_O) |->
            $past(s.ctrl[PEM_CTRL_MODE]) && $past(over_lvl);
    endproperty
    a_mode_only: assert property (p_mode_only)
        else $error("overflow alarm outside position mode");

    property p_ovf_stop;
        s.ctrl[PEM_CTRL_MODE] && over_lvl |=> ERROR_OVERFLOW_ALARM_O && MOTOR_STOP_O;
    endproperty
    a_ovf_stop: assert property (p_ovf_stop)
        else $error("overflow did not alarm and stop");

    property p_level_range;
        s.level >= PEM_LEVEL_MIN;
    endproperty
    a_level_range: assert property (p_level_range)
        else $error("alarm level out of range");

    property p_follow;
        s.ctrl[PEM_CTRL_FSEL] |-> gain_sel == s.fgain;
    endproperty
    a_follow: assert property (p_follow)
        else $error("follower gain not used");

    property p_shown;
        addr_take && !HWRITE_I && HADDR_I == 32'(PEM_SHOWN_ADDR)
            && s.ctrl[PEM_CTRL_DISP] != PEM_DISP_ALL |=> HRDATA_O == 32'h0000_0000;
    endproperty
    a_shown: assert property (p_shown)
        else $error("loop gain shown while hidden");

    property p_cap_arm;
        SERVO_ON_I && !s.servo && s.err != 32'sh0000_0000 |=>
            SPEED_LIMIT_EN_O && CLEARING_O;
    endproperty
    a_cap_arm: assert property (p_cap_arm)
        else $error("speed cap not armed at power-on");

    property p_pon;
        SERVO_ON_I && !s.servo && over_pon |=> POWERON_OVERFLOW_ALARM_O [*2];
    endproperty
    a_pon: assert property (p_pon)
        else $error("power-on overflow missed");

    property p_cap_max;
        SPEED_LIMIT_EN_O |-> SPEED_LIMIT_O <= PEM_CAP_MAX;
    endproperty
    a_cap_max: assert property (p_cap_max)
        else $error("speed cap above maximum");

    property p_capovf;
        s.cap_act && REF_VALID_I && over_lvl |=> CAPPED_SPEED_OVERFLOW_ALARM_O;
    endproperty
    a_capovf: assert property (p_capovf)
        else $error("capped speed overflow missed");

    property p_neg;
        s.ctrl[PEM_CTRL_MODE] && s.err < -$signed({2'h0, s.level})
            |=> ERROR_OVERFLOW_ALARM_O;
    endproperty
    a_neg: assert property (p_neg)
        else $error("negative overflow missed");

    c_ovf: cover property ($rose(ERROR_OVERFLOW_ALARM_O));
    c_pon: cover property ($rose(POWERON_OVERFLOW_ALARM_O));
    c_cap: cover property ($rose(SPEED_LIMIT_EN_O) ##[1:50] $fell(SPEED_LIMIT_EN_O));
    c_irq: cover property ($rose(IRQ_O));
endmodule // pemon_top
`default_nettype wire
